// ==== hw/jtb_defines.vh ====
// Constants for the boundary-scan test access port
`ifndef JTB_DEFINES_VH
`define JTB_DEFINES_VH

// Scan register lengths
`define JTB_IR_LEN        3
`define JTB_ID_LEN        32
`define JTB_BSR_LEN       107

// Instruction codes
`define JTB_INS_EXTEST    3'h0
`define JTB_INS_IDCODE    3'h1
`define JTB_INS_SAMPLE    3'h2
`define JTB_INS_PRELOAD   3'h4
`define JTB_INS_BYPASS    3'h7
`define JTB_IR_CAPTURE    3'h1

// Identification field positions
`define JTB_ID_REV_LSB    28
`define JTB_ID_PART_LSB   12
`define JTB_ID_VEND_LSB   1

// Tap states
`define JTB_ST_TLR        4'h0
`define JTB_ST_RTI        4'h1
`define JTB_ST_SELDR      4'h2
`define JTB_ST_CAPDR      4'h3
`define JTB_ST_SHDR       4'h4
`define JTB_ST_EX1DR      4'h5
`define JTB_ST_PAUSEDR    4'h6
`define JTB_ST_EX2DR      4'h7
`define JTB_ST_UPDDR      4'h8
`define JTB_ST_SELIR      4'h9
`define JTB_ST_CAPIR      4'hA
`define JTB_ST_SHIR       4'hB
`define JTB_ST_EX1IR      4'hC
`define JTB_ST_PAUSEIR    4'hD
`define JTB_ST_EX2IR      4'hE
`define JTB_ST_UPDIR      4'hF

`endif

// ==== hw/jtb_shift_reg.v ====
// Capture/shift register used for the identification and boundary paths
`timescale 1ns/1ps
`default_nettype none
module jtb_shift_reg #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input  wire             mclk_i,
	input  wire             nrst_i,
	// Control
	input  wire             capture_i,
	input  wire             shift_i,
	input  wire             sin_i,
	input  wire [WIDTH-1:0] pdata_i,
	// Serial out
	output wire             sout_o
);
	reg [WIDTH-1:0] data;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			data <= {WIDTH{1'b0}};
		end else if (capture_i) begin
			data <= pdata_i;
		end else if (shift_i) begin
			data <= {sin_i, data[WIDTH-1:1]};
		end
	end

	assign sout_o = data[0];
endmodule // jtb_shift_reg
`default_nettype wire

// ==== hw/jtb_tap.v ====
// Boundary-scan test access port: tap controller, instruction and data registers
`timescale 1ns/1ps
`default_nettype none
`include "jtb_defines.vh"
module jtb_tap #(
	// Identification fields; values are arbitrary
	parameter [3:0]  ID_REV  = 4'h0,
	parameter [15:0] ID_PART = 16'h1234,
	parameter [10:0] ID_VEND = 11'h0AB
) (
	// Clock and reset
	input  wire                    mclk_i,
	input  wire                    nrst_i,
	// Test port pins
	input  wire                    tck_i,
	input  wire                    tms_i,
	input  wire                    tdi_i,
	output reg                     tdo_o,
	output reg                     tdo_oe_o,
	// Device I/O ring, bit 0 is exit position 1
	input  wire [`JTB_BSR_LEN-1:0] ring_i,
	// Tap status
	output reg  [3:0]              tap_state_o,
	output reg  [`JTB_IR_LEN-1:0]  instr_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and test clock edge detection
	reg [2:0] tck_sync;
	reg [1:0] tms_sync;
	reg [1:0] tdi_sync;
	wire      tck_rise = tck_sync[1] & ~tck_sync[2];
	wire      tck_fall = ~tck_sync[1] & tck_sync[2];

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// Idle-high level, so no false rise is seen just after release
			tck_sync <= 3'h7;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h0;
		end else begin
			tck_sync <= {tck_sync[1:0], tck_i};
			tms_sync <= {tms_sync[0], tms_i};
			tdi_sync <= {tdi_sync[0], tdi_i};
		end
	end

	// Mode select and data are delayed as much as the clock, so they are taken as at the edge
	wire tms = tms_sync[1];
	wire tdi = tdi_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Tap state machine
	reg [3:0] state;
	reg [3:0] next_state;

	always @* begin
		case (state)
			`JTB_ST_TLR:     next_state = tms ? `JTB_ST_TLR   : `JTB_ST_RTI;
			`JTB_ST_RTI:     next_state = tms ? `JTB_ST_SELDR : `JTB_ST_RTI;
			`JTB_ST_SELDR:   next_state = tms ? `JTB_ST_SELIR : `JTB_ST_CAPDR;
			`JTB_ST_CAPDR:   next_state = tms ? `JTB_ST_EX1DR : `JTB_ST_SHDR;
			`JTB_ST_SHDR:    next_state = tms ? `JTB_ST_EX1DR : `JTB_ST_SHDR;
			`JTB_ST_EX1DR:   next_state = tms ? `JTB_ST_UPDDR : `JTB_ST_PAUSEDR;
			`JTB_ST_PAUSEDR: next_state = tms ? `JTB_ST_EX2DR : `JTB_ST_PAUSEDR;
			`JTB_ST_EX2DR:   next_state = tms ? `JTB_ST_UPDDR : `JTB_ST_SHDR;
			`JTB_ST_UPDDR:   next_state = tms ? `JTB_ST_SELDR : `JTB_ST_RTI;
			`JTB_ST_SELIR:   next_state = tms ? `JTB_ST_TLR   : `JTB_ST_CAPIR;
			`JTB_ST_CAPIR:   next_state = tms ? `JTB_ST_EX1IR : `JTB_ST_SHIR;
			`JTB_ST_SHIR:    next_state = tms ? `JTB_ST_EX1IR : `JTB_ST_SHIR;
			`JTB_ST_EX1IR:   next_state = tms ? `JTB_ST_UPDIR : `JTB_ST_PAUSEIR;
			`JTB_ST_PAUSEIR: next_state = tms ? `JTB_ST_EX2IR : `JTB_ST_PAUSEIR;
			`JTB_ST_EX2IR:   next_state = tms ? `JTB_ST_UPDIR : `JTB_ST_SHIR;
			`JTB_ST_UPDIR:   next_state = tms ? `JTB_ST_SELDR : `JTB_ST_RTI;
			default:         next_state = `JTB_ST_TLR;
		endcase
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= `JTB_ST_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instruction register
	reg [`JTB_IR_LEN-1:0] ir_shift;
	reg [`JTB_IR_LEN-1:0] ir;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir_shift <= `JTB_IR_CAPTURE;
			ir       <= `JTB_INS_IDCODE;
		end else if (tck_rise) begin
			// Loaded on entry, so the reset state never shows a stale instruction
			if (next_state == `JTB_ST_TLR) begin
				ir <= `JTB_INS_IDCODE;
			end else if (state == `JTB_ST_UPDIR) begin
				ir <= ir_shift;
			end
			if (state == `JTB_ST_CAPIR) begin
				ir_shift <= `JTB_IR_CAPTURE;
			end else if (state == `JTB_ST_SHIR) begin
				ir_shift <= {tdi, ir_shift[`JTB_IR_LEN-1:1]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data register selection
	function [1:0] dr_sel;
		input [`JTB_IR_LEN-1:0] code;
		begin
			case (code)
				`JTB_INS_IDCODE:  dr_sel = 2'h1;
				`JTB_INS_EXTEST,
				`JTB_INS_SAMPLE,
				`JTB_INS_PRELOAD: dr_sel = 2'h2;
				default:          dr_sel = 2'h0;
			endcase
		end
	endfunction

	wire [1:0] sel      = dr_sel(ir);
	wire       cap_dr   = tck_rise && (state == `JTB_ST_CAPDR);
	wire       sh_dr    = tck_rise && (state == `JTB_ST_SHDR);
	wire       id_sel   = (sel == 2'h1);
	wire       bsr_sel  = (sel == 2'h2);
	wire [`JTB_ID_LEN-1:0] id_value = {ID_REV, ID_PART, ID_VEND, 1'b1};
	wire       id_out;
	wire       bsr_out;
	reg        bypass;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bypass <= 1'b0;
		end else if (cap_dr) begin
			bypass <= 1'b0;
		end else if (sh_dr) begin
			bypass <= tdi;
		end
	end

	// Identification path, lengths from the header
	jtb_shift_reg #(
		.WIDTH(`JTB_ID_LEN)
	) u_id (
		.mclk_i   (mclk_i),
		.nrst_i   (nrst_i),
		.capture_i(cap_dr && id_sel),
		.shift_i  (sh_dr && id_sel),
		.sin_i    (tdi),
		.pdata_i  (id_value),
		.sout_o   (id_out)
	);

	// Boundary path; position n of the exit order is ring bit n-1
	jtb_shift_reg #(
		.WIDTH(`JTB_BSR_LEN)
	) u_bsr (
		.mclk_i   (mclk_i),
		.nrst_i   (nrst_i),
		.capture_i(cap_dr && bsr_sel),
		.shift_i  (sh_dr && bsr_sel),
		.sin_i    (tdi),
		.pdata_i  (ring_i),
		.sout_o   (bsr_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Serial output, launched on the falling test clock edge
	reg next_tdo;

	always @* begin
		if (state == `JTB_ST_SHIR) begin
			next_tdo = ir_shift[0];
		end else if (id_sel) begin
			next_tdo = id_out;
		end else if (bsr_sel) begin
			next_tdo = bsr_out;
		end else begin
			next_tdo = bypass;
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tdo_o       <= 1'b0;
			tdo_oe_o    <= 1'b0;
			tap_state_o <= `JTB_ST_TLR;
			instr_o     <= `JTB_INS_IDCODE;
		end else begin
			tap_state_o <= state;
			instr_o     <= ir;
			if (tck_fall) begin
				tdo_o    <= next_tdo;
				tdo_oe_o <= (state == `JTB_ST_SHDR) || (state == `JTB_ST_SHIR);
			end
		end
	end
endmodule // jtb_tap
`default_nettype wire

// ==== verif/jtb_ctl_model.sv ====
// Behavioural scan controller driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module jtb_ctl_model (
	input  wire logic mclk_i,
	output var logic  tck_o,
	output var logic  tms_o,
	output var logic  tdi_o
);
	initial begin
		tck_o = 1'b1;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// One 400 ns period; pins move only at the fall, so the rise sees them settled
	task automatic step(input logic ms, input logic di);
		@(posedge mclk_i);
		tck_o <= 1'b0;
		tms_o <= ms;
		tdi_o <= di;
		repeat (4) @(posedge mclk_i);
		tck_o <= 1'b1;
		repeat (3) @(posedge mclk_i);
	endtask
endmodule // jtb_ctl_model
`default_nettype wire

// ==== verif/jtb_tap_props.sv ====
// Checker on the test port pins and tap status
`timescale 1ns/1ps
`default_nettype none
`include "jtb_defines.vh"
module jtb_tap_props (
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       tck_i,
	input wire logic       tms_i,
	input wire logic       tdo_o,
	input wire logic       tdo_oe_o,
	input wire logic [3:0] tap_state_o,
	input wire logic [2:0] instr_o
);
	// Edge finder runs a flop ahead of the design, so its counts lead
	logic [1:0] tck_s;
	logic [2:0] ones;
	logic [3:0] n_rise;
	logic [3:0] n_fall;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tck_s  <= 2'h3;
			ones   <= 3'h0;
			n_rise <= 4'hF;
			n_fall <= 4'hF;
		end else begin
			tck_s  <= {tck_s[0], tck_i};
			ones   <= tck_s != 2'h1 ? ones : tms_i ? ones + {2'h0, ones != 3'h5} : 3'h0;
			n_rise <= tck_s == 2'h1 ? 4'h0 : n_rise + {3'h0, n_rise != 4'hF};
			n_fall <= tck_s == 2'h2 ? 4'h0 : n_fall + {3'h0, n_fall != 4'hF};
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_tlr3;
		(tap_state_o == `JTB_ST_TLR) [*3];
	endsequence
	AST_PWR_UP: assert property ($rose(nrst_i) |-> tap_state_o == `JTB_ST_TLR && !tdo_oe_o)
		else $error("no reset state");
	AST_ST_RISE: assert property ($changed(tap_state_o) |-> n_rise < 4'h6)
		else $error("state moved off a rise");
	AST_TDO_FALL: assert property ($changed(tdo_o) |-> n_fall < 4'h6)
		else $error("data out moved off a fall");
	AST_OE_SHIFT: assert property ($rose(tdo_oe_o) |-> n_fall < 4'h6 &&
		tap_state_o inside {`JTB_ST_SHDR, `JTB_ST_SHIR}) else $error("drive outside shift");
	AST_FIVE: assert property ($rose(ones == 3'h5) |-> ##[0:6] tap_state_o == `JTB_ST_TLR)
		else $error("five ones missed reset");
	AST_TLR_ID: assert property (s_tlr3 |-> instr_o == `JTB_INS_IDCODE)
		else $error("reset state without id code");
	AST_IR_UPD: assert property ($changed(instr_o) |-> tap_state_o inside
		{`JTB_ST_UPDIR, `JTB_ST_TLR, `JTB_ST_RTI, `JTB_ST_SELDR}) else $error("stray instr");
	AST_SHDR_OUT: assert property ($changed(tap_state_o) && $past(tap_state_o) == `JTB_ST_SHDR
		|-> tap_state_o == `JTB_ST_EX1DR) else $error("bad shift exit");
endmodule // jtb_tap_props
bind jtb_tap jtb_tap_props u_props (.mclk_i, .nrst_i, .tck_i, .tms_i, .tdo_o, .tdo_oe_o,
	.tap_state_o, .instr_o);
`default_nettype wire

// ==== verif/jtb_tap_tb_top.sv ====
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtb_defines.vh"
module jtb_tap_tb_top;
	// Identification fields; values are arbitrary
	localparam logic [31:0] id_val = {4'h5, 16'h00C3, 11'h155, 1'b1};
	logic         mclk_i = 1'b0;
	logic         nrst_i = 1'b0;
	logic         tck, tms, tdi, tdo, tdo_oe;
	logic [106:0] ring = 107'h0;
	logic [3:0]   st;
	logic [2:0]   ins;
	logic [127:0] tv;
	logic         exp_q[$];
	int           fail_count = 0;
	int           compares = 0;
	always #25 mclk_i = ~mclk_i;
	jtb_tap #(.ID_REV(4'h5), .ID_PART(16'h00C3), .ID_VEND(11'h155)) dut (.mclk_i, .nrst_i,
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_i(ring),
		.tap_state_o(st), .instr_o(ins));
	jtb_ctl_model u_ctl (.mclk_i, .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
	task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic walk(input logic [7:0] seq, input int n);
		for (int i = 0; i < n; i++)
			u_ctl.step(seq[i], 1'($urandom));
	endtask
	// Queue each expected bit, exit on the last one, then update and idle
	task automatic scan(input int n, input logic [127:0] exp, input logic [127:0] din);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(exp[i]);
			u_ctl.step(i == n - 1, din[i]);
		end
		walk(8'h01, 2);
	endtask
	task automatic complete_run;
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge tck)
		if (tdo_oe === 1'b1)
			cmp({3'h0, tdo}, exp_q.size() > 0 ? {3'h0, exp_q.pop_front()} : 4'hF);
	initial begin
		#2000000;
		fail_count++;
		complete_run();
	end
	initial begin
		void'($urandom(46991));
		repeat (4) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		cmp(st, `JTB_ST_TLR);
		walk(8'h00, 1);
		for (int c = 0; c < 8; c++) begin
			ring <= 107'({$urandom, $urandom, $urandom, $urandom});
			tv = {$urandom, $urandom, $urandom, $urandom};
			walk(8'h03, 4);
			scan(3, 128'h1, 128'(c));
			repeat (3) @(posedge mclk_i);
			cmp({1'b0, ins}, 4'(c));
			walk(8'h01, 3);
			if (c == 0 || c == 2 || c == 4)
				scan(107, 128'(ring), tv);
			else if (c == 1)
				scan(32, 128'(id_val), tv);
			else
				scan(8, {tv[126:0], 1'b0}, tv);
		end
		walk(8'h15, 6);
		exp_q.push_back(1'b0);
		walk(8'h1F, 5);
		repeat (3) @(posedge mclk_i);
		cmp(st, `JTB_ST_TLR);
		cmp({1'b0, ins}, {1'b0, `JTB_INS_IDCODE});
		cmp({3'h0, exp_q.size() != 0}, 4'h0);
		complete_run();
	end
endmodule // jtb_tap_tb_top
`default_nettype wire
